/* risc8_datapath_model.sv */
/* datapath stand-in facing the decoder: test result, flags, address hits.
   assumes the bench picks the test outcome through wantTrue. */
`timescale 1ns/10ps
`default_nettype none
module risc8_datapath_model (
  input  wire logic       execValid,
  input  wire logic [7:0] fileAddr,
  input  wire logic       wantTrue,
  output logic            testTrue,
  output logic            fileIsPort,
  output logic            fileIsTimerZero,
  output logic [4:0]      aluFlags
);
  // same-cycle answers; flags vary with the address
  always_comb begin
    testTrue = execValid & wantTrue;
    aluFlags = fileAddr[4:0] ^ 5'h0a;
    fileIsPort = (fileAddr == 8'h80); // one port register
    fileIsTimerZero = (fileAddr == 8'h81);
  end
endmodule
`default_nettype wire

/* risc8_decoder_checker.sv */
/* concurrent checks on the instruction decoder ports.
   assumes it is bound onto the decoder and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
`include "risc8_decoder_consts.vh"
module risc8_decoder_checker (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        wordValid,
  input wire logic [15:0] progWord,
  input wire logic        testTrue,
  input wire logic [4:0]  aluFlags,
  input wire logic        fileIsPort,
  input wire logic        fileIsTimerZero,
  input wire logic        prescalerAssigned,
  input wire logic        execValid,
  input wire logic [5:0]  opClass,
  input wire logic        writeToFile,
  input wire logic        useBankPointer,
  input wire logic [7:0]  fileAddr,
  input wire logic [2:0]  bitPos,
  input wire logic [7:0]  literal,
  input wire logic [10:0] longOffset,
  input wire logic [7:0]  shortOffset,
  input wire logic [11:0] srcAddr,
  input wire logic [11:0] dstAddr,
  input wire logic [19:0] jumpTarget,
  input wire logic [4:0]  flagMask,
  input wire logic [4:0]  statusFlags,
  input wire logic        readFromPins,
  input wire logic        clearPrescaler
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // next word is squashed, even after idle
  logic squashDue;
  wire  squashNow = squashDue || execValid && (opClass inside {[`OP_FAR_JUMP:`OP_BRA], `OP_RET} ||
    testTrue && opClass inside {[`OP_CPLT:`OP_DSNZ], `OP_BCOND});
  always @(posedge clock) squashDue <= rst_b && squashNow && !wordValid;
  // ****************************************
  // pairing sequences
  // ****************************************
  // clean head: two idle cycles, then a word
  sequence cleanHead;
    !execValid && !$past(execValid) && wordValid;
  endsequence
  sequence moveWords;
    (cleanHead and progWord[15:12] == 4'hc) ##1 wordValid && progWord[15:12] == 4'hf;
  endsequence
  sequence jumpWords;
    (cleanHead and progWord[15:8] == 8'hef) ##1 wordValid && progWord[15:12] == 4'hf;
  endsequence
  // ****************************************
  // decode and flag checks
  // ****************************************
  flags_track_a: assert property (execValid |=> statusFlags == (($past(aluFlags) & $past(flagMask)) |
    ($past(statusFlags) & ~$past(flagMask)))) else $error("status flags not merged by mask");
  flags_hold_a: assert property (!execValid |=> $stable(statusFlags)) else $error("flags moved without op");
  no_flags_a: assert property (execValid && opClass inside {`OP_STORE, `OP_MUL, `OP_CPLT, `OP_CPEQ,
    `OP_CPGT, `OP_DSZ, `OP_ISZ, `OP_ISNZ, `OP_DSNZ, `OP_NOP} |-> flagMask == `FM_NONE) else $error("mask not empty");
  zn_mask_a: assert property (execValid && opClass inside {`OP_OR, `OP_AND, `OP_XOR, `OP_INV,
    `OP_MOVE_FILE, `OP_RL, `OP_RR} |-> flagMask == `FM_ZN) else $error("mask not zero and negative");
  all_mask_a: assert property (execValid && opClass inside {`OP_ADD, `OP_ADDC, `OP_SUBFB, `OP_SUBAB,
    `OP_SUB, `OP_NEG} |-> flagMask == `FM_ALL) else $error("mask not all five flags");
  rot_clear_a: assert property (execValid && opClass inside {`OP_RLC, `OP_RRC, `OP_ZERO} |->
    flagMask == ((opClass == `OP_ZERO) ? `FM_Z : `FM_CZN)) else $error("rotate or clear mask wrong");
  field_slice_a: assert property (wordValid && !squashNow && progWord[15:12] != 4'hf |=> execValid &&
    fileAddr == $past(progWord[7:0]) &&
    bitPos == $past(progWord[11:9]) && literal == $past(progWord[7:0]) &&
    longOffset == $past(progWord[10:0]) && shortOffset == $past(progWord[7:0])) else $error("field slice wrong");
  dest_bank_a: assert property (wordValid && !squashNow && progWord[15:10] == 6'h09 |=>
    writeToFile == $past(progWord[9]) && useBankPointer == $past(progWord[8])) else $error("d or a bit wrong");
  squash_next_a: assert property (wordValid && squashNow |=>
    opClass == `OP_NOP && flagMask == `FM_NONE) else $error("word not squashed");
  port_read_a: assert property (execValid && opClass == `OP_ADD |-> readFromPins == fileIsPort &&
    clearPrescaler == (fileIsTimerZero && prescalerAssigned && writeToFile)) else $error("pin or prescaler wrong");
  move_pair_a: assert property (moveWords |=> opClass == `OP_FILE_TO_FILE_MOVE && srcAddr == $past(progWord[11:0], 2) &&
    dstAddr == $past(progWord[11:0])) else $error("file move pairing wrong");
  jump_pair_a: assert property (jumpWords |=> opClass == `OP_FAR_JUMP &&
    jumpTarget == {$past(progWord[11:0]), $past(progWord[7:0], 2)}) else $error("jump target wrong");
  orphan_word_a: assert property ((cleanHead and progWord[15:12] == 4'hf) |=> opClass == `OP_NOP)
    else $error("orphan second word not a no-op");
endmodule
bind risc8_instruction_decoder risc8_decoder_checker checker_i (.clock(clock), .rst_b(rst_b),
  .wordValid(wordValid), .progWord(progWord), .testTrue(testTrue), .aluFlags(aluFlags),
  .fileIsPort(fileIsPort), .fileIsTimerZero(fileIsTimerZero), .prescalerAssigned(prescalerAssigned),
  .execValid(execValid), .opClass(opClass), .writeToFile(writeToFile), .useBankPointer(useBankPointer),
  .fileAddr(fileAddr), .bitPos(bitPos), .literal(literal), .longOffset(longOffset), .shortOffset(shortOffset),
  .srcAddr(srcAddr), .dstAddr(dstAddr), .jumpTarget(jumpTarget), .flagMask(flagMask),
  .statusFlags(statusFlags), .readFromPins(readFromPins), .clearPrescaler(clearPrescaler));
`default_nettype wire

/* risc8_decoder_consts.vh */
/*
 * constants for the 8-bit core instruction decoder: opcode classes,
 * instruction word fields, prefixes, status flag width and masks.
 * assumes it is included by bare name from the decoder, checker and bench sources.
 */
`ifndef RISC8_DECODER_CONSTS_VH
`define RISC8_DECODER_CONSTS_VH

// ****************************************
// instruction word fields
// ****************************************
`define W_PREFIX    15:12
`define W_SUBOP     11:8
`define W_DEST      9
`define W_ACCESS    8
`define W_FILE      7:0
`define W_BITPOS    11:9
`define W_LIT       7:0
`define W_LONG_OFS  10:0
`define W_SHORT_OFS 7:0
`define W_ADDR12    11:0
`define W_COND      10:8
`define W_FAST      8
`define W_RET_FAST  0

// ****************************************
// prefixes and fixed words
// ****************************************
`define PFX_FIRST_MOVE 4'hc
`define PFX_SECOND     4'hf
`define PFX_RELJUMP    4'hd
`define PFX_CONTROL    4'he
`define SUB_FARJUMP    4'hf
`define SUB_CALL       3'h6
`define SUB_LITERAL    4'he
`define SUB_MULTIPLY   3'h1
`define RETURN_UPPER   15'h0009

// ****************************************
// decoded operation classes
// ****************************************
`define OP_NOP   6'h00
`define OP_OTHER 6'h01
`define OP_ADD   6'h02
`define OP_ADDC  6'h03
`define OP_INC   6'h04
`define OP_DEC   6'h05
`define OP_OR    6'h06
`define OP_AND   6'h07
`define OP_XOR   6'h08
`define OP_INV   6'h09
`define OP_MOVE_FILE  6'h0a
`define OP_SUBFB 6'h0b
`define OP_SUBAB 6'h0c
`define OP_SUB   6'h0d
`define OP_CPLT  6'h0e
`define OP_CPEQ  6'h0f
`define OP_CPGT  6'h10
`define OP_TSTZ  6'h11
`define OP_DSZ   6'h12
`define OP_ISZ   6'h13
`define OP_ISNZ  6'h14
`define OP_DSNZ  6'h15
`define OP_RLC   6'h16
`define OP_RRC   6'h17
`define OP_RL    6'h18
`define OP_RR    6'h19
`define OP_SWAP  6'h1a
`define OP_STORE 6'h1b
`define OP_MUL   6'h1c
`define OP_ZERO  6'h1d
`define OP_NEG   6'h1e
`define OP_SETF  6'h1f
`define OP_FILE_TO_FILE_MOVE 6'h20
`define OP_FAR_JUMP  6'h21
`define OP_CALL  6'h22
`define OP_BRA   6'h23
`define OP_BCOND 6'h24
`define OP_LIT   6'h25
`define OP_RET   6'h26

// ****************************************
// status flags: width, update masks and reset value
// ****************************************
`define FLAG_W   5
`define FM_NONE  5'h00
`define FM_Z     5'h04
`define FM_ZN    5'h14
`define FM_CZN   5'h15
`define FM_ALL   5'h1f
`define FLAGS_RST 5'h00

`endif

/* risc8_instruction_decoder.v */
/*
 * instruction decoder of the 8-bit accumulator core: splits each
 * fetched 16-bit word into its fields, pairs two-word instructions,
 * squashes words after a jump or a true test, and keeps the status
 * flags using the update mask of the executed instruction.
 * assumes the fetch unit and datapath share this clock; datapath
 * inputs answer combinationally for the op currently on the outputs.
 */
// Overview of operation
// - d=0 result to accumulator, d=1 to file
// - a=0 access bank, a=1 bank pointer
// - byte and bit ops: file address low byte
// - file move: two words, prefixes 1100/1111
// - bit ops: bit position in bits 11:9
// - literal ops: immediate in low byte
// - jump/call: 20-bit target, second word 1111
// - always-branch: 11-bit offset, bits 10:0
// - conditional branch: 8-bit offset low byte
// - add and add-carry codes, five flags
// - logic ops under 0001, zero/negative only
// - subtracts under 0101, move_file zero/negative
// - compare-skips under 0110, no flags
// - count-and-skip codes, no flags changed
// - rotates: carry versions also update carry
// - store/multiply no flags, clear Z, negate all
// - skip costs one or two extra cycles
// - port read-modify-write reads pin levels
// - marked op on timer clears its prescaler
// - pc change or true test: second cycle NOP
// - orphan second word executes as NOP
// - fast bit saves/restores shadow registers
`include "risc8_decoder_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module risc8_instruction_decoder (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        wordValid,
  input  wire [15:0] progWord,
  input  wire        testTrue,
  input  wire [4:0]  aluFlags,
  input  wire        fileIsPort,
  input  wire        fileIsTimerZero,
  input  wire        prescalerAssigned,
  output reg         execValid,
  output reg  [5:0]  opClass,
  output reg  [15:0] rawWord,
  output reg         writeToFile,
  output reg         useBankPointer,
  output reg  [7:0]  fileAddr,
  output reg  [2:0]  bitPos,
  output reg  [7:0]  literal,
  output reg  [10:0] longOffset,
  output reg  [7:0]  shortOffset,
  output reg  [2:0]  branchCond,
  output reg  [11:0] srcAddr,
  output reg  [11:0] dstAddr,
  output reg  [19:0] jumpTarget,
  output reg  [4:0]  flagMask,
  output reg  [4:0]  statusFlags,
  output reg         shadowSave,
  output reg         shadowRestore,
  output wire        readFromPins,
  output wire        clearPrescaler
);

  // ****************************************
  // pairing states
  // ****************************************
  localparam ST_ONE    = 1'b0;
  localparam ST_SECOND = 1'b1;

  reg        state;
  reg        killPending;
  reg [5:0]  firstOp;
  reg [11:0] firstLow;
  reg        firstFast;
  reg        opTests;
  reg        opJumps;
  reg        opRmw;
  reg        opMarked;
  reg        opUsesD;

  // combinational decode results
  reg [5:0]  next_op;
  reg [4:0]  next_mask;
  reg        next_tests;
  reg        next_jumps;
  reg        next_rmw;
  reg        next_marked;
  reg        next_usesD;
  reg        next_startPair;

  wire [3:0] prefix = progWord[`W_PREFIX];
  wire [3:0] subOp  = progWord[`W_SUBOP];

  // a jump or true test squashes the next valid word
  wire killNow = killPending | (execValid & opJumps)
               | (execValid & opTests & testTrue);
  wire accept  = wordValid & ~killNow;

  // ****************************************
  // side-effect strobes
  // ****************************************
  // port operand comes from the pins, latch would hide input levels
  assign readFromPins   = execValid & opRmw & fileIsPort;
  // d matters only for ops that carry a destination bit
  assign clearPrescaler = execValid & opMarked & fileIsTimerZero & prescalerAssigned
                        & (~opUsesD | writeToFile);

  // ****************************************
  // opcode decode
  // ****************************************
  always @* begin
    next_op        = `OP_OTHER;
    next_mask      = `FM_NONE;
    next_tests     = 1'b0;
    next_jumps     = 1'b0;
    next_rmw       = 1'b0;
    next_marked    = 1'b0;
    next_usesD     = 1'b1;
    next_startPair = 1'b0;
    case (prefix)
      4'h0: begin
        if (progWord[11:9] == `SUB_MULTIPLY) begin
          next_op     = `OP_MUL;
          next_rmw    = 1'b1;
          next_marked = 1'b1;
          next_usesD  = 1'b0;
        end else if (subOp == 4'h1 || subOp == 4'h0) begin
          if (progWord[15:1] == `RETURN_UPPER) begin
            next_op    = `OP_RET;
            next_jumps = 1'b1;
          end else if (subOp == 4'h0) begin
            next_op = (progWord == 16'h0000) ? `OP_NOP : `OP_OTHER;
          end
        end else if (subOp[3:2] == 2'b01) begin
          next_op     = `OP_DEC;
          next_mask   = `FM_ALL;
          next_rmw    = 1'b1;
          next_marked = 1'b1;
        end else if (subOp == `SUB_LITERAL) begin
          next_op = `OP_LIT;
        end
      end
      4'h1: begin
        next_mask = `FM_ZN;
        next_rmw  = 1'b1;
        case (subOp[3:2])
          2'b00: next_op = `OP_OR;
          2'b01: next_op = `OP_AND;
          2'b10: next_op = `OP_XOR;
          default: next_op = `OP_INV;
        endcase
        next_marked = (subOp[3:2] != 2'b10);
        next_rmw    = (subOp[3:2] != 2'b10);
      end
      4'h2: begin
        next_rmw    = 1'b1;
        next_marked = 1'b1;
        case (subOp[3:2])
          2'b00: begin
            next_op   = `OP_ADDC;
            next_mask = `FM_ALL;
          end
          2'b01: begin
            next_op   = `OP_ADD;
            next_mask = `FM_ALL;
          end
          2'b10: begin
            next_op   = `OP_INC;
            next_mask = `FM_ALL;
          end
          default: begin
            next_op    = `OP_DSZ;
            next_tests = 1'b1;
          end
        endcase
      end
      4'h3: begin
        case (subOp[3:2])
          2'b00: begin
            next_op   = `OP_RRC;
            next_mask = `FM_CZN;
          end
          2'b01: begin
            next_op     = `OP_RLC;
            next_mask   = `FM_CZN;
            next_rmw    = 1'b1;
            next_marked = 1'b1;
          end
          2'b10: next_op = `OP_SWAP;
          default: begin
            next_op    = `OP_ISZ;
            next_tests = 1'b1;
          end
        endcase
      end
      4'h4: begin
        case (subOp[3:2])
          2'b00: begin
            next_op   = `OP_RR;
            next_mask = `FM_ZN;
          end
          2'b01: begin
            next_op   = `OP_RL;
            next_mask = `FM_ZN;
          end
          2'b10: next_op = `OP_ISNZ;
          default: next_op = `OP_DSNZ;
        endcase
        next_tests  = subOp[3];
        next_rmw    = subOp[3];
        next_marked = subOp[3];
      end
      4'h5: begin
        next_mask = `FM_ALL;
        case (subOp[3:2])
          2'b00: begin
            next_op   = `OP_MOVE_FILE;
            next_mask = `FM_ZN;
            next_rmw  = 1'b1;
          end
          2'b01: next_op = `OP_SUBFB;
          2'b10: next_op = `OP_SUBAB;
          default: begin
            next_op     = `OP_SUB;
            next_rmw    = 1'b1;
            next_marked = 1'b1;
          end
        endcase
      end
      4'h6: begin
        next_usesD = 1'b0;
        case (progWord[11:9])
          3'h0: begin
            next_op     = `OP_CPLT;
            next_tests  = 1'b1;
            next_rmw    = 1'b1;
            next_marked = 1'b1;
          end
          3'h1: begin
            next_op    = `OP_CPEQ;
            next_tests = 1'b1;
          end
          3'h2: begin
            next_op    = `OP_CPGT;
            next_tests = 1'b1;
          end
          3'h3: begin
            next_op     = `OP_TSTZ;
            next_tests  = 1'b1;
            next_marked = 1'b1;
          end
          3'h4: begin
            next_op     = `OP_SETF;
            next_marked = 1'b1;
          end
          3'h5: begin
            next_op     = `OP_ZERO;
            next_mask   = `FM_Z;
            next_marked = 1'b1;
          end
          3'h6: begin
            next_op   = `OP_NEG;
            next_mask = `FM_ALL;
          end
          default: next_op = `OP_STORE;
        endcase
      end
      `PFX_FIRST_MOVE: begin
        next_op        = `OP_FILE_TO_FILE_MOVE;
        next_startPair = 1'b1;
      end
      `PFX_RELJUMP: begin
        if (!progWord[11]) begin
          next_op    = `OP_BRA;
          next_jumps = 1'b1;
        end
      end
      `PFX_CONTROL: begin
        if (!progWord[11]) begin
          next_op    = `OP_BCOND;
          next_tests = 1'b1;
        end else if (subOp == `SUB_FARJUMP) begin
          next_op        = `OP_FAR_JUMP;
          next_startPair = 1'b1;
        end else if (progWord[11:9] == `SUB_CALL) begin
          next_op        = `OP_CALL;
          next_startPair = 1'b1;
        end
      end
      `PFX_SECOND: next_op = `OP_NOP;
      default: next_op = `OP_OTHER;
    endcase
  end

  // ****************************************
  // field capture, pairing and squashing
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      state          <= ST_ONE;
      killPending    <= 1'b0;
      firstOp        <= `OP_NOP;
      firstLow       <= 12'h000;
      firstFast      <= 1'b0;
      execValid      <= 1'b0;
      opClass        <= `OP_NOP;
      rawWord        <= 16'h0000;
      writeToFile    <= 1'b0;
      useBankPointer <= 1'b0;
      fileAddr       <= 8'h00;
      bitPos         <= 3'h0;
      literal        <= 8'h00;
      longOffset     <= 11'h000;
      shortOffset    <= 8'h00;
      branchCond     <= 3'h0;
      srcAddr        <= 12'h000;
      dstAddr        <= 12'h000;
      jumpTarget     <= 20'h00000;
      flagMask       <= `FM_NONE;
      opTests        <= 1'b0;
      opJumps        <= 1'b0;
      opRmw          <= 1'b0;
      opMarked       <= 1'b0;
      opUsesD        <= 1'b1;
      shadowSave     <= 1'b0;
      shadowRestore  <= 1'b0;
    end else begin
      execValid <= wordValid;
      // squash request waits for the next word if none is here yet
      killPending <= killNow & ~wordValid;
      // default: a squashed or first-half word runs as a no-op
      opClass       <= `OP_NOP;
      flagMask      <= `FM_NONE;
      opTests       <= 1'b0;
      opJumps       <= 1'b0;
      opRmw         <= 1'b0;
      opMarked      <= 1'b0;
      shadowSave    <= 1'b0;
      shadowRestore <= 1'b0;
      if (wordValid) begin
        rawWord <= progWord;
      end
      if (wordValid && killNow) begin
        state <= ST_ONE;
      end else if (accept && state == ST_SECOND) begin
        state <= ST_ONE;
        if (prefix == `PFX_SECOND) begin
          opClass <= firstOp;
          srcAddr <= firstLow;
          dstAddr <= progWord[`W_ADDR12];
          jumpTarget <= {progWord[`W_ADDR12], firstLow[7:0]};
          opJumps <= (firstOp != `OP_FILE_TO_FILE_MOVE);
          shadowSave <= (firstOp == `OP_CALL) & firstFast;
        end
      end else if (accept) begin
        writeToFile    <= progWord[`W_DEST];
        useBankPointer <= progWord[`W_ACCESS];
        fileAddr       <= progWord[`W_FILE];
        bitPos         <= progWord[`W_BITPOS];
        literal        <= progWord[`W_LIT];
        longOffset     <= progWord[`W_LONG_OFS];
        shortOffset    <= progWord[`W_SHORT_OFS];
        branchCond     <= progWord[`W_COND];
        opUsesD        <= next_usesD;
        if (next_startPair) begin
          // first half holds no work; the next accepted word pairs only if it is 1111
          state     <= ST_SECOND;
          firstOp   <= next_op;
          firstLow  <= progWord[`W_ADDR12];
          firstFast <= progWord[`W_FAST];
        end else begin
          opClass       <= next_op;
          flagMask      <= next_mask;
          opTests       <= next_tests;
          opJumps       <= next_jumps;
          opRmw         <= next_rmw;
          opMarked      <= next_marked;
          shadowRestore <= (next_op == `OP_RET) & progWord[`W_RET_FAST];
        end
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // only masked flags take the datapath result, the rest hold
  always @(posedge clock) begin
    if (!rst_b) begin
      statusFlags <= `FLAGS_RST;
    end else if (execValid) begin
      statusFlags <= (statusFlags & ~flagMask) | (aluFlags & flagMask);
    end
  end

endmodule

`default_nettype wire

/* risc8_instruction_decoder_tb_top.sv */
/* self-checking bench for the instruction decoder.
   assumes the datapath model and the bound checker are compiled too. */
`timescale 1ns/10ps
`default_nettype none
`include "risc8_decoder_consts.vh"
module risc8_instruction_decoder_tb_top;
  logic        clock, rst_b, wordValid, wantTrue, prescalerAssigned, testTrue, fileIsPort, fileIsTimerZero;
  logic        execValid, writeToFile, useBankPointer, shadowSave, shadowRestore, readFromPins, clearPrescaler;
  logic [15:0] progWord, rawWord;
  logic [5:0]  opClass;
  logic [7:0]  fileAddr, literal, shortOffset;
  logic [2:0]  bitPos, branchCond;
  logic [10:0] longOffset;
  logic [11:0] srcAddr, dstAddr;
  logic [19:0] jumpTarget;
  logic [4:0]  flagMask, statusFlags, aluFlags;
  int          errorCnt = 0;
  int          cmpCount = 0;
  // byte op table: upper byte with a=0 (d=0 where the op has a d bit), expected class and flag mask
  logic [7:0]  hiByte [25] = '{8'h24, 8'h20, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h34,
    8'h30, 8'h44, 8'h40, 8'h6e, 8'h02, 8'h6a, 8'h6c, 8'h60, 8'h62, 8'h64, 8'h2c, 8'h3c, 8'h48, 8'h4c};
  logic [5:0]  hiCls [25] = '{`OP_ADD, `OP_ADDC, `OP_OR, `OP_AND, `OP_XOR, `OP_INV, `OP_MOVE_FILE, `OP_SUBFB,
    `OP_SUBAB, `OP_SUB, `OP_RLC, `OP_RRC, `OP_RL, `OP_RR, `OP_STORE, `OP_MUL, `OP_ZERO, `OP_NEG, `OP_CPLT,
    `OP_CPEQ, `OP_CPGT, `OP_DSZ, `OP_ISZ, `OP_ISNZ, `OP_DSNZ};
  logic [4:0]  hiMsk [25] = '{5'h1f, 5'h1f, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h1f, 5'h1f, 5'h1f, 5'h15,
    5'h15, 5'h14, 5'h14, 5'h00, 5'h00, 5'h04, 5'h1f, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  // ****************************************
  // structure
  // ****************************************
  risc8_instruction_decoder dut (.clock(clock), .rst_b(rst_b), .wordValid(wordValid), .progWord(progWord),
    .testTrue(testTrue), .aluFlags(aluFlags), .fileIsPort(fileIsPort), .fileIsTimerZero(fileIsTimerZero),
    .prescalerAssigned(prescalerAssigned), .execValid(execValid), .opClass(opClass), .rawWord(rawWord),
    .writeToFile(writeToFile), .useBankPointer(useBankPointer), .fileAddr(fileAddr), .bitPos(bitPos),
    .literal(literal), .longOffset(longOffset), .shortOffset(shortOffset), .branchCond(branchCond),
    .srcAddr(srcAddr), .dstAddr(dstAddr), .jumpTarget(jumpTarget), .flagMask(flagMask),
    .statusFlags(statusFlags), .shadowSave(shadowSave), .shadowRestore(shadowRestore),
    .readFromPins(readFromPins), .clearPrescaler(clearPrescaler));
  risc8_datapath_model far_i (.execValid(execValid), .fileAddr(fileAddr), .wantTrue(wantTrue),
    .testTrue(testTrue), .fileIsPort(fileIsPort), .fileIsTimerZero(fileIsTimerZero), .aluFlags(aluFlags));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // word held one cycle; valid stays up between words
  task automatic send(input logic [15:0] w);
    progWord = w;
    wordValid = 1'b1;
    @(negedge clock);
  endtask
  task automatic idle(input int n);
    wordValid = 1'b0;
    repeat (n) @(negedge clock);
  endtask
  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // 25 byte ops back to back; flags checked one word late, as they land
  task automatic t_byte;
    logic [4:0] expSt;
    logic [7:0] f;
    expSt = 5'h00;
    for (int i = 0; i < 25; i++) begin
      f = 8'(i * 7);
      send({hiByte[i] | {7'h00, i[0]}, f});
      chk("decode", {opClass, flagMask, useBankPointer, fileAddr}, {hiCls[i], hiMsk[i], i[0], f});
      chk("statusFlags", {15'h0, statusFlags}, {15'h0, expSt});
      expSt = ((f[4:0] ^ 5'h0a) & hiMsk[i]) | (expSt & ~hiMsk[i]);
    end
    $display("test byte ops done");
  endtask
  task automatic t_fields;
    send(16'h2601);
    chk("destBank", {18'h0, writeToFile, useBankPointer}, 20'h2);
    send(16'h25ff);
    chk("destBank", {18'h0, writeToFile, useBankPointer}, 20'h1);
    send(16'h9a5c);
    chk("bitField", {9'h0, bitPos, fileAddr}, {9'h0, 3'h5, 8'h5c});
    send(16'h0e7f);
    chk("literal", {rawWord[15:4], literal}, {12'h0e7, 8'h7f});
    send(16'he2c4);
    chk("condBranch", {9'h0, branchCond, shortOffset}, {9'h0, 3'h2, 8'hc4});
    send(16'hd5a3);
    chk("relJump", {3'h0, opClass, longOffset}, {3'h0, `OP_BRA, 11'h5a3});
    send(16'h2401);
    chk("squashed", {9'h0, opClass, flagMask}, {9'h0, `OP_NOP, `FM_NONE});
    $display("test fields done");
  endtask
  // two-word ops; a filler after each jump absorbs its squash
  task automatic t_pair;
    idle(3);
    send(16'hc123);
    send(16'hf456);
    chk("move", {2'h0, opClass, srcAddr}, {2'h0, `OP_FILE_TO_FILE_MOVE, 12'h123});
    chk("moveDst", {8'h0, dstAddr}, 20'h00456);
    idle(3);
    send(16'hef34);
    send(16'hf012);
    chk("jumpTarget", jumpTarget, 20'h01234);
    send(16'h0000);
    send(16'hed55);
    send(16'hfabc);
    chk("callTarget", jumpTarget, 20'habc55);
    chk("shadowSave", {19'h0, shadowSave}, 20'h1);
    send(16'h0000);
    send(16'hec55);
    send(16'hf000);
    chk("shadowSave", {19'h0, shadowSave}, 20'h0);
    send(16'h0000);
    idle(3);
    send(16'hf777);
    chk("orphan", {9'h0, opClass, flagMask}, {9'h0, `OP_NOP, `FM_NONE});
    $display("test pairs done");
  endtask
  // true compare skips a two-word jump: three cycles, jump never taken
  task automatic t_skip;
    send(16'h6201);
    wantTrue = 1'b1;
    send(16'hef34);
    chk("skipFirst", {14'h0, opClass}, {14'h0, `OP_NOP});
    wantTrue = 1'b0;
    send(16'hf012);
    chk("skipSecond", {14'h0, opClass}, {14'h0, `OP_NOP});
    send(16'h2401);
    chk("afterSkip", {14'h0, opClass}, {14'h0, `OP_ADD});
    $display("test skip done");
  endtask
  task automatic t_port;
    prescalerAssigned = 1'b1;
    send(16'h2680);
    chk("portRmw", {18'h0, readFromPins, clearPrescaler}, 20'h2);
    send(16'h2681);
    chk("portRmw", {18'h0, readFromPins, clearPrescaler}, 20'h1);
    send(16'h2481);
    chk("portRmw", {18'h0, readFromPins, clearPrescaler}, 20'h0);
    prescalerAssigned = 1'b0;
    send(16'h2681);
    chk("portRmw", {18'h0, readFromPins, clearPrescaler}, 20'h0);
    send(16'h0013);
    chk("return", {13'h0, shadowRestore, opClass}, {13'h0, 1'b1, `OP_RET});
    $display("test port done");
  endtask
  // ****************************************
  // clock, sequence and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    rst_b = 1'b0;
    wordValid = 1'b0;
    progWord = 16'h0000;
    wantTrue = 1'b0;
    prescalerAssigned = 1'b0;
    repeat (3) @(negedge clock);
    chk("reset", {13'h0, execValid, opClass}, {13'h0, 1'b0, `OP_NOP});
    chk("resetFlags", {15'h0, statusFlags}, {15'h0, `FLAGS_RST});
    rst_b = 1'b1;
    t_byte;
    t_fields;
    t_pair;
    t_skip;
    t_port;
    idle(2);
    completeRun;
  end
  // tests need about 67 cycles; about six times that means a hang
  initial begin
    #(400 * 50);
    errorCnt++;
    completeRun;
  end
endmodule
`default_nettype wire
